// ---- rtl/dbc_comparators.sv ----
// Purpose: Match qualification for three debug bus comparators A, B, C.
// Assumes: Bus and instruction queue inputs synchronous to sys_clk.
// Notes: Matches and session end are one-cycle registered pulses.
`timescale 1ns/1ps
module dbc_comparators (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Debug module state
  input wire logic module_armed,
  // Processor bus
  input wire logic cpu_valid,
  input wire logic [17:0] cpu_addr,
  input wire logic [15:0] cpu_data,
  input wire logic cpu_read,
  input wire logic cpu_byte,
  input wire logic cpu_fetch,
  // Instruction queue execution stage
  input wire logic exec_valid,
  input wire logic [17:0] exec_addr,
  // Match results
  output logic [2:0] match_out,
  output logic session_end,
  output logic break_req,
  output logic disarm
);

  logic [7:0] ctl1_reg;
  logic [15:0] data_reg;
  logic [15:0] mask_reg;
  logic [7:0] rdata_reg;
  logic [2:0] match_reg;
  logic session_end_reg;
  logic break_req_reg;
  logic [7:0] ctl_q [dbc_pkg::DBC_NCH];
  logic [17:0] addr_q [dbc_pkg::DBC_NCH];
  logic [2:0] hit;
  logic [2:0] tag_pend;
  logic [2:0] tag_fire;
  logic [2:0] imm_hit;

  // Window decode
  wire [1:0] wsel = ctl1_reg[dbc_pkg::DBC_WSEL_LSB +: 2];
  wire bp_en = ctl1_reg[dbc_pkg::DBC_BPEN_BIT];
  wire win_none = (wsel == dbc_pkg::DBC_WIN_NONE);
  wire win_a = (wsel == dbc_pkg::DBC_WIN_A);
  wire wr_win = clk_en & reg_wr & ~module_armed & ~win_none;
  wire wr_ctl1 = clk_en & reg_wr & (reg_addr == dbc_pkg::DBC_CTL1_OFS);
  wire at_ctl = (reg_addr == dbc_pkg::DBC_CTL_OFS);
  wire at_ah = (reg_addr == dbc_pkg::DBC_AH_OFS);
  wire at_am = (reg_addr == dbc_pkg::DBC_AM_OFS);
  wire at_al = (reg_addr == dbc_pkg::DBC_AL_OFS);
  wire at_dh = (reg_addr == dbc_pkg::DBC_DH_OFS);
  wire at_dl = (reg_addr == dbc_pkg::DBC_DL_OFS);
  wire at_mh = (reg_addr == dbc_pkg::DBC_MH_OFS);
  wire at_ml = (reg_addr == dbc_pkg::DBC_ML_OFS);
  wire wr_a_data = wr_win & win_a;

  // Debug control one: window select and breakpoint enable
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctl1_reg <= dbc_pkg::DBC_RST_BYTE;
    end else if (wr_ctl1) begin
      ctl1_reg <= reg_wdata & dbc_pkg::DBC_CTL1_MASK;
    end
  end

  // Data compare and mask, comparator A only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      data_reg <= dbc_pkg::DBC_RST_WORD;
      mask_reg <= dbc_pkg::DBC_RST_WORD;
    end else if (wr_a_data) begin
      if (at_dh) data_reg[15:8] <= reg_wdata;
      if (at_dl) data_reg[7:0] <= reg_wdata;
      if (at_mh) mask_reg[15:8] <= reg_wdata;
      if (at_ml) mask_reg[7:0] <= reg_wdata;
    end
  end

  // Per-comparator bank and match logic
  genvar gi;
  generate
    for (gi = 0; gi < dbc_pkg::DBC_NCH; gi = gi + 1) begin : g_ch
      localparam logic [7:0] CMASK = (gi == 0) ? dbc_pkg::DBC_CTL_MASK_A :
                                     (gi == 1) ? dbc_pkg::DBC_CTL_MASK_B :
                                     dbc_pkg::DBC_CTL_MASK_C;
      logic [7:0] ctl_reg;
      logic [17:0] cmp_reg;
      logic pend_reg;
      wire sel = (wsel == 2'(gi));
      wire wr_sel = wr_win & sel;
      wire cmp_en = ctl_reg[dbc_pkg::DBC_ENABLE_BIT];
      wire tag = ctl_reg[dbc_pkg::DBC_TAG_BIT];
      wire size_en = ctl_reg[dbc_pkg::DBC_SIZE_EN_BIT];
      wire size_val = ctl_reg[dbc_pkg::DBC_SIZE_VAL_BIT];
      wire dir_en = ctl_reg[dbc_pkg::DBC_DIR_EN_BIT];
      wire dir_val = ctl_reg[dbc_pkg::DBC_RW_BIT];
      wire mismatch_sel = ctl_reg[dbc_pkg::DBC_MISMATCH_BIT];
      wire addr_hit = (cpu_addr == cmp_reg);
      wire size_ok = ~size_en | (cpu_byte == size_val);
      wire rw_ok = ~dir_en | (cpu_read == dir_val);
      wire data_eq = (((cpu_data ^ data_reg) & mask_reg) == 16'h0000);
      wire data_ok = (gi != 0) | (data_eq ^ mismatch_sel);
      // Tag mode skips size, direction and data qualifiers
      wire imm = cmp_en & ~tag & cpu_valid & addr_hit & size_ok & rw_ok & data_ok;
      wire tag_set = cmp_en & tag & cpu_valid & cpu_fetch & addr_hit;
      wire fire = cmp_en & pend_reg & exec_valid & (exec_addr == cmp_reg);

      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          ctl_reg <= dbc_pkg::DBC_RST_BYTE;
          cmp_reg <= dbc_pkg::DBC_RST_ADDR;
        end else if (clk_en && wr_sel) begin
          if (at_ctl) ctl_reg <= reg_wdata & CMASK;
          if (at_ah) cmp_reg[17:16] <= reg_wdata[1:0];
          if (at_am) cmp_reg[15:8] <= reg_wdata;
          if (at_al) cmp_reg[7:0] <= reg_wdata;
        end
      end

      // Tagged opcode waits for the execution stage
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          pend_reg <= 1'b0;
        end else if (clk_en) begin
          if (!cmp_en || !tag) begin
            pend_reg <= 1'b0;
          end else if (tag_set) begin
            pend_reg <= 1'b1;
          end else if (fire) begin
            pend_reg <= 1'b0;
          end
        end
      end

      assign ctl_q[gi] = ctl_reg;
      assign addr_q[gi] = cmp_reg;
      assign imm_hit[gi] = imm;
      assign tag_fire[gi] = fire;
      assign tag_pend[gi] = pend_reg;
      assign hit[gi] = imm | fire;
    end
  endgenerate

  // Immediate session end on a break channel
  wire [2:0] break_bits = {ctl_q[2][dbc_pkg::DBC_BREAK_BIT], ctl_q[1][dbc_pkg::DBC_BREAK_BIT],
                           ctl_q[0][dbc_pkg::DBC_BREAK_BIT]};
  wire break_hit = |(hit & break_bits);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      match_reg <= 3'h0;
      session_end_reg <= 1'b0;
      break_req_reg <= 1'b0;
    end else if (clk_en) begin
      match_reg <= hit;
      session_end_reg <= break_hit;
      break_req_reg <= break_hit & bp_en;
    end
  end

  // Read-back selection
  wire [1:0] wi = win_none ? 2'b00 : wsel;
  wire [7:0] ah_byte = {6'h00, addr_q[wi][17:16]};
  wire [7:0] win_byte = at_ctl ? ctl_q[wi] :
                        at_ah ? ah_byte :
                        at_am ? addr_q[wi][15:8] :
                        at_al ? addr_q[wi][7:0] : 8'h00;
  wire [7:0] a_byte = at_dh ? data_reg[15:8] :
                      at_dl ? data_reg[7:0] :
                      at_mh ? mask_reg[15:8] :
                      at_ml ? mask_reg[7:0] : 8'h00;
  wire [7:0] rd_next = (reg_addr == dbc_pkg::DBC_CTL1_OFS) ? ctl1_reg :
                       win_none ? 8'h00 :
                       (win_byte | (win_a ? a_byte : 8'h00));

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= reg_rd ? rd_next : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign match_out = match_reg;
  assign session_end = session_end_reg;
  assign break_req = break_req_reg;
  assign disarm = session_end_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wire in_data_area = at_dh | at_dl | at_mh | at_ml;
  wire in_window = at_ctl | at_ah | at_am | at_al | in_data_area;

  property p_none_reads_zero;
    clk_en && reg_rd && win_none && in_window |=> reg_rdata == 8'h00;
  endproperty
  a_none_reads_zero: assert property (p_none_reads_zero)
    else $error("window select 11 returned nonzero data");

  property p_unimpl_reads_zero;
    clk_en && reg_rd && !win_a && in_data_area |=> reg_rdata == 8'h00;
  endproperty
  a_unimpl_reads_zero: assert property (p_unimpl_reads_zero)
    else $error("unimplemented data byte read nonzero");

  property p_armed_blocks_write;
    clk_en && reg_wr && module_armed && at_ctl && win_a |=> ctl_q[0] == $past(ctl_q[0]);
  endproperty
  a_armed_blocks_write: assert property (p_armed_blocks_write)
    else $error("control changed while armed");

  property p_ctl_read_b;
    clk_en && reg_rd && at_ctl && wsel == dbc_pkg::DBC_WIN_B && !(reg_wr)
      |=> reg_rdata == $past(ctl_q[1]);
  endproperty
  a_ctl_read_b: assert property (p_ctl_read_b)
    else $error("comparator B control not read back");

  property p_b_no_mismatch_sel;
    ctl_q[1][dbc_pkg::DBC_MISMATCH_BIT] == 1'b0;
  endproperty
  a_b_no_mismatch_sel: assert property (p_b_no_mismatch_sel)
    else $error("comparator B data mismatch bit set");

  property p_c_no_size;
    ctl_q[2][7:6] == 2'b00;
  endproperty
  a_c_no_size: assert property (p_c_no_size)
    else $error("comparator C size bits set");

  property p_disabled_quiet;
    clk_en && !ctl_q[0][dbc_pkg::DBC_ENABLE_BIT] |=> !match_out[0];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled comparator A matched");

  property p_break_gated;
    clk_en && break_hit && !bp_en |=> session_end && !break_req;
  endproperty
  a_break_gated: assert property (p_break_gated)
    else $error("breakpoint without enable or missing session end");

  property p_rw_mismatch;
    clk_en && cpu_valid && !ctl_q[0][dbc_pkg::DBC_TAG_BIT] && ctl_q[0][dbc_pkg::DBC_DIR_EN_BIT]
      && (cpu_read != ctl_q[0][dbc_pkg::DBC_RW_BIT]) |-> !imm_hit[0];
  endproperty
  a_rw_mismatch: assert property (p_rw_mismatch)
    else $error("comparator A matched wrong direction");

  property p_addr_mismatch;
    clk_en && cpu_valid && (cpu_addr != addr_q[1]) && !tag_fire[1] |=> !match_out[1];
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch)
    else $error("comparator B matched wrong address");

  property p_size_mismatch;
    clk_en && cpu_valid && ctl_q[0][dbc_pkg::DBC_SIZE_EN_BIT] && !ctl_q[0][dbc_pkg::DBC_TAG_BIT]
      && (cpu_byte != ctl_q[0][dbc_pkg::DBC_SIZE_VAL_BIT]) |-> !imm_hit[0];
  endproperty
  a_size_mismatch: assert property (p_size_mismatch)
    else $error("comparator A matched wrong size");

  property p_tag_waits;
    clk_en && tag_pend[0] && !exec_valid |-> !hit[0];
  endproperty
  a_tag_waits: assert property (p_tag_waits)
    else $error("tagged comparator A fired before execution");

  property p_c_no_mismatch_sel;
    ctl_q[2][dbc_pkg::DBC_MISMATCH_BIT] == 1'b0;
  endproperty
  a_c_no_mismatch_sel: assert property (p_c_no_mismatch_sel)
    else $error("comparator C data mismatch bit set");

  property p_ah_upper_zero;
    clk_en && reg_rd && at_ah |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_ah_upper_zero: assert property (p_ah_upper_zero)
    else $error("address high upper bits read nonzero");

  property p_rd_idle_zero;
    clk_en && !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data nonzero without a read");

  property p_mask_read;
    clk_en && reg_rd && win_a && at_ml && !reg_wr
      |=> reg_rdata == $past(mask_reg[7:0]);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("comparator A mask low not read back");

  property p_unimpl_write_ignored;
    clk_en && reg_wr && !win_a && in_data_area |=> $stable(data_reg) && $stable(mask_reg);
  endproperty
  a_unimpl_write_ignored: assert property (p_unimpl_write_ignored)
    else $error("data or mask changed outside window A");

  property p_armed_blocks_addr;
    clk_en && reg_wr && module_armed && in_window
      |=> $stable(addr_q[0]) && $stable(addr_q[1]) && $stable(addr_q[2]);
  endproperty
  a_armed_blocks_addr: assert property (p_armed_blocks_addr)
    else $error("compare address changed while armed");

  property p_none_blocks_write;
    clk_en && reg_wr && win_none && in_window
      |=> $stable(ctl_q[0]) && $stable(ctl_q[1]) && $stable(ctl_q[2]);
  endproperty
  a_none_blocks_write: assert property (p_none_blocks_write)
    else $error("control changed with no comparator visible");

  property p_break_end;
    clk_en && break_hit |=> session_end && disarm;
  endproperty
  a_break_end: assert property (p_break_end)
    else $error("break match did not end the session");

  property p_bp_en_break;
    clk_en && break_hit && bp_en |=> break_req;
  endproperty
  a_bp_en_break: assert property (p_bp_en_break)
    else $error("enabled breakpoint not raised");

  property p_fire_match;
    clk_en && tag_fire[0] |=> match_out[0];
  endproperty
  a_fire_match: assert property (p_fire_match)
    else $error("executed tagged opcode gave no match");

  property p_b_ignores_data;
    clk_en && cpu_valid && ctl_q[1] == 8'h01 && cpu_addr == addr_q[1] |=> match_out[1];
  endproperty
  a_b_ignores_data: assert property (p_b_ignores_data)
    else $error("comparator B missed an address match");

  property p_data_mismatch;
    clk_en && cpu_valid && !ctl_q[0][dbc_pkg::DBC_MISMATCH_BIT]
      && (((cpu_data ^ data_reg) & mask_reg) != 16'h0000) |-> !imm_hit[0];
  endproperty
  a_data_mismatch: assert property (p_data_mismatch)
    else $error("comparator A matched differing masked data");

endmodule

// ---- rtl/dbc_pkg.sv ----
// Purpose: Constants for the debug bus comparator block.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes: Offsets are byte addresses on the register port.
package dbc_pkg;

  // Register offsets
  localparam logic [15:0] DBC_CTL1_OFS = 16'h0026;
  localparam logic [15:0] DBC_CTL_OFS = 16'h0028;
  localparam logic [15:0] DBC_AH_OFS = 16'h0029;
  localparam logic [15:0] DBC_AM_OFS = 16'h002A;
  localparam logic [15:0] DBC_AL_OFS = 16'h002B;
  localparam logic [15:0] DBC_DH_OFS = 16'h002C;
  localparam logic [15:0] DBC_DL_OFS = 16'h002D;
  localparam logic [15:0] DBC_MH_OFS = 16'h002E;
  localparam logic [15:0] DBC_ML_OFS = 16'h002F;

  // Comparator control fields
  localparam int DBC_SIZE_EN_BIT = 7;
  localparam int DBC_SIZE_VAL_BIT = 6;
  localparam int DBC_TAG_BIT = 5;
  localparam int DBC_BREAK_BIT = 4;
  localparam int DBC_RW_BIT = 3;
  localparam int DBC_DIR_EN_BIT = 2;
  localparam int DBC_MISMATCH_BIT = 1;
  localparam int DBC_ENABLE_BIT = 0;

  // Debug control one fields
  localparam int DBC_BPEN_BIT = 4;
  localparam int DBC_WSEL_LSB = 0;
  localparam logic [7:0] DBC_CTL1_MASK = 8'h13;

  // Implemented bits per comparator
  localparam logic [7:0] DBC_CTL_MASK_A = 8'hFF;
  localparam logic [7:0] DBC_CTL_MASK_B = 8'hFD;
  localparam logic [7:0] DBC_CTL_MASK_C = 8'h3D;
  localparam logic [7:0] DBC_AH_MASK = 8'h03;

  // Reset values
  localparam logic [7:0] DBC_RST_BYTE = 8'h00;
  localparam logic [17:0] DBC_RST_ADDR = 18'h00000;
  localparam logic [15:0] DBC_RST_WORD = 16'h0000;

  localparam int DBC_NCH = 3;

  // Window select encodings
  typedef enum logic [1:0] {
    DBC_WIN_A = 2'b00,
    DBC_WIN_B = 2'b01,
    DBC_WIN_C = 2'b10,
    DBC_WIN_NONE = 2'b11
  } dbc_wsel_e;

endpackage

// ---- test/dbc_cpu_model.sv ----
// Purpose: Processor bus and instruction queue model for the comparators.
// Assumes: Called just after a rising edge of sys_clk.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module dbc_cpu_model (
  // Clock
  input wire logic sys_clk,
  // Processor bus
  output logic cpu_valid,
  output logic [17:0] cpu_addr,
  output logic [15:0] cpu_data,
  output logic cpu_read,
  output logic cpu_byte,
  output logic cpu_fetch,
  // Execution stage
  output logic exec_valid,
  output logic [17:0] exec_addr
);
  initial begin
    {cpu_valid, cpu_read, cpu_byte, cpu_fetch, exec_valid} = 5'h00;
    cpu_addr = 18'h00000;
    cpu_data = 16'h0000;
    exec_addr = 18'h00000;
  end
  // One bus cycle of one clock
  task automatic cycle(input logic [17:0] a, input logic [15:0] d, input logic rd,
                       input logic by, input logic f);
    cpu_valid <= 1'b1;
    cpu_addr <= a;
    cpu_data <= d;
    cpu_read <= rd;
    cpu_byte <= by;
    cpu_fetch <= f;
    @(posedge sys_clk);
    cpu_valid <= 1'b0;
    cpu_addr <= ~a;
    cpu_data <= ~d;
    cpu_fetch <= 1'b0;
  endtask
  task automatic execute(input logic [17:0] a);
    exec_valid <= 1'b1;
    exec_addr <= a;
    @(posedge sys_clk);
    exec_valid <= 1'b0;
    exec_addr <= ~a;
  endtask
endmodule

// ---- test/testbench.sv ----
// Purpose: Register and match tests for the debug bus comparators.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Match outputs are checked in the cycle after the bus cycle.
`timescale 1ns/1ps
module testbench;
  localparam logic [17:0] AD = 18'h21234;
  localparam logic [15:0] D = 16'h553A;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic module_armed = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_rdata;
  logic cpu_valid, cpu_read, cpu_byte, cpu_fetch, exec_valid;
  logic [17:0] cpu_addr, exec_addr;
  logic [15:0] cpu_data;
  logic [2:0] match_out;
  logic session_end, break_req, disarm;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  dbc_comparators dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .module_armed(module_armed), .cpu_valid(cpu_valid),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_read(cpu_read), .cpu_byte(cpu_byte),
    .cpu_fetch(cpu_fetch), .exec_valid(exec_valid), .exec_addr(exec_addr),
    .match_out(match_out), .session_end(session_end), .break_req(break_req),
    .disarm(disarm));
  dbc_cpu_model cpu (.sys_clk(sys_clk), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .cpu_read(cpu_read), .cpu_byte(cpu_byte), .cpu_fetch(cpu_fetch),
    .exec_valid(exec_valid), .exec_addr(exec_addr));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  // Bus cycle, then session_end, break_req, disarm and match_out in one byte
  task automatic bus(input logic [17:0] a, input logic [15:0] d, input logic r,
                     input logic by, input logic f, input logic [7:0] exp);
    cpu.cycle(a, d, r, by, f);
    #1;
    check("match", {2'b00, session_end, break_req, disarm, match_out}, exp);
  endtask
  task automatic set_addr(input logic [17:0] a);
    wr(dbc_pkg::DBC_AH_OFS, {6'h00, a[17:16]});
    wr(dbc_pkg::DBC_AM_OFS, a[15:8]);
    wr(dbc_pkg::DBC_AL_OFS, a[7:0]);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    rd(dbc_pkg::DBC_CTL1_OFS, 8'h00);
    rd(dbc_pkg::DBC_CTL_OFS, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'hFF);
    rd(dbc_pkg::DBC_CTL_OFS, 8'hFF);
    wr(dbc_pkg::DBC_AH_OFS, 8'hFF);
    rd(dbc_pkg::DBC_AH_OFS, 8'h03);
    rd(16'h0030, 8'h00);
    wr(dbc_pkg::DBC_CTL1_OFS, 8'h01);
    wr(dbc_pkg::DBC_CTL_OFS, 8'hFF);
    rd(dbc_pkg::DBC_CTL_OFS, 8'hFD);
    wr(dbc_pkg::DBC_DH_OFS, 8'h5A);
    rd(dbc_pkg::DBC_DH_OFS, 8'h00);
    set_addr(AD);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h01);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h02);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h00);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL1_OFS, 8'h02);
    wr(dbc_pkg::DBC_CTL_OFS, 8'hFF);
    rd(dbc_pkg::DBC_CTL_OFS, 8'h3D);
    wr(dbc_pkg::DBC_AL_OFS, 8'h77);
    wr(dbc_pkg::DBC_CTL1_OFS, 8'h03);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h12);
    rd(dbc_pkg::DBC_CTL_OFS, 8'h00);
    rd(dbc_pkg::DBC_AL_OFS, 8'h00);
    wr(dbc_pkg::DBC_CTL1_OFS, 8'h00);
    rd(dbc_pkg::DBC_AL_OFS, 8'h00);
    module_armed <= 1'b1;
    wr(dbc_pkg::DBC_CTL_OFS, 8'h00);
    rd(dbc_pkg::DBC_CTL_OFS, 8'hFF);
    module_armed <= 1'b0;
    clk_en <= 1'b0;
    wr(dbc_pkg::DBC_CTL_OFS, 8'h00);
    clk_en <= 1'b1;
    rd(dbc_pkg::DBC_CTL_OFS, 8'hFF);
    $display("test registers done");
    set_addr(AD);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h01);
    bus(AD, D, 1'b1, 1'b1, 1'b0, 8'h01);
    bus(AD ^ 18'h00001, D, 1'b0, 1'b0, 1'b0, 8'h00);
    bus(AD ^ 18'h20000, D, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h00);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h05);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h01);
    bus(AD, D, 1'b1, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h0D);
    bus(AD, D, 1'b1, 1'b0, 1'b0, 8'h01);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'hC1);
    bus(AD, D, 1'b0, 1'b1, 1'b0, 8'h01);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h81);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h01);
    bus(AD, D, 1'b0, 1'b1, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h41);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h01);
    $display("test qualifiers done");
    wr(dbc_pkg::DBC_DH_OFS, 8'h55);
    wr(dbc_pkg::DBC_DL_OFS, 8'hAA);
    wr(dbc_pkg::DBC_MH_OFS, 8'hFF);
    wr(dbc_pkg::DBC_ML_OFS, 8'h0F);
    rd(dbc_pkg::DBC_ML_OFS, 8'h0F);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h01);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h01);
    bus(AD, 16'h56AA, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h03);
    bus(AD, 16'h56AA, 1'b0, 1'b0, 1'b0, 8'h01);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h00);
    $display("test data done");
    wr(dbc_pkg::DBC_CTL_OFS, 8'h11);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h29);
    wr(dbc_pkg::DBC_CTL1_OFS, 8'h10);
    bus(AD, D, 1'b0, 1'b0, 1'b0, 8'h39);
    bus(AD ^ 18'h00100, D, 1'b0, 1'b0, 1'b0, 8'h00);
    wr(dbc_pkg::DBC_CTL_OFS, 8'h25);
    bus(AD, 16'h0000, 1'b1, 1'b0, 1'b1, 8'h00);
    bus(AD ^ 18'h00100, D, 1'b0, 1'b0, 1'b0, 8'h00);
    cpu.execute(AD);
    #1;
    check("tag fire", {5'h00, match_out}, 8'h01);
    cpu.execute(AD);
    #1;
    check("tag once", {5'h00, match_out}, 8'h00);
    $display("test break and tag done");
    end_sim();
  end
endmodule
